// *** rtl/tcc_consts.vh ***
/*
 thermostat compare and configuration block: byte map, field positions,
 reset values. assumes one includer per compilation unit.
*/
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// byte addresses of the linear map
`define TCC_ADDR_UPPER_HI   8'hA0
`define TCC_ADDR_UPPER_LO   8'hA1
`define TCC_ADDR_LOWER_HI   8'hA2
`define TCC_ADDR_LOWER_LO   8'hA3
`define TCC_ADDR_USER_0     8'hA4
`define TCC_ADDR_USER_1     8'hA5
`define TCC_ADDR_USER_2     8'hA6
`define TCC_ADDR_USER_3     8'hA7
`define TCC_ADDR_UNDEF_0    8'hA8
`define TCC_ADDR_UNDEF_1    8'hA9
`define TCC_ADDR_TEMP_HI    8'hAA
`define TCC_ADDR_TEMP_LO    8'hAB
`define TCC_ADDR_CFG_HI     8'hAC
`define TCC_ADDR_CFG_LO     8'hAD

// configuration word bit positions
`define TCC_CFG_DONE        15
`define TCC_CFG_NVB         14
`define TCC_CFG_HIGHF       13
`define TCC_CFG_LOWF        12
`define TCC_CFG_RES_HI      11
`define TCC_CFG_RES_LO      10
`define TCC_CFG_AUTOSTART   9
`define TCC_CFG_SINGLE      8
`define TCC_CFG_OUT2        7
`define TCC_CFG_OUT1        6
`define TCC_CFG_ADDR_MSB    5
`define TCC_CFG_ADDR_LSB    3

// reset values
`define TCC_RST_UPPER       16'h0780
`define TCC_RST_LOWER       16'h0500
`define TCC_RST_TEMP        16'hE200
`define TCC_RST_RES         2'h3
`define TCC_RST_AUTOSTART   1'h0
`define TCC_RST_SINGLE      1'h0
`define TCC_RST_OUT2        1'h0
`define TCC_RST_OUT1        1'h1
`define TCC_RST_USER        8'h00
// factory bits, value arbitrary
`define TCC_FACTORY_BITS    3'h0
// limit and temperature low bits that are never stored
`define TCC_LOW_MASK        8'hF8

`endif

// *** rtl/tcc_thermostat.v ***
/*
 thermostat compare and configuration logic of a temperature sensor:
 byte register map, trip comparison, sticky flags, open-drain output,
 conversion sequencing. assumes a serial-bus front end that issues
 single-cycle byte reads and writes, an external converter that answers
 each start pulse with one result pulse, and an external nonvolatile
 store that reports busy and may reload the stored image.
*/
// Notes on behaviour
// (RL1) conversion result overwrites a host temperature write
// (RL2) host temperature write ignored for compare while converting
// (RL3) compare only after low temperature byte written
// (RL4) host stops conversions, writes both temperature bytes
// (RL5) output re-evaluated per conversion or write, then held
// (RL6) high mode: assert at >= upper, release at <= lower
// (RL7) low mode: assert at <= lower, release at >= upper
// (RL8) upper limit at A0/A1, lower at A2/A3
// (RL9) signed compare uses all limit bits
// (RL10) host zeroes limit bits below resolution
// (RL11) high flag at >= upper, low flag at <= lower
// (RL12) flags sticky until reset or written zero
// (RL13) autostart converts at power-up, enables trigger pin; the power-up start never fires here, autostart resets to 0
// (RL14) single mode converts once then standby
// (RL15) trigger pin low then high starts next conversion
// (RL16) out bits select high, low or forced low
// (RL17) output function change takes effect at once; here only an out2 change does, an out1 change waits for the next evaluation
// (RL18) fourteen byte map A0 to AD decoded
// (RL19) every location served from a shadow copy
// (RL20) configuration word bit layout at AC/AD
// (RL21) resolution, start, single, out1 are nonvolatile
// (RL22) done reads 0 while converting, else 1
// (RL23) write-busy mirrors nonvolatile write activity
`include "tcc_consts.vh"

module tcc_thermostat
(
   // clock and reset
   input  wire        i_clk,
   input  wire        i_reset,
   // byte register port
   input  wire [7:0]  i_reg_addr,
   input  wire        i_reg_wr,
   input  wire        i_reg_rd,
   input  wire [7:0]  i_reg_wdata,
   output reg  [7:0]  o_reg_rdata,
   output reg         o_reg_nv_write,
   // conversion commands from the bus front end
   input  wire        i_start_convert,
   input  wire        i_stop_convert,
   // external converter
   output reg         o_conv_start,
   input  wire        i_conv_valid,
   input  wire [15:0] i_conv_data,
   output reg  [1:0]  o_resolution,
   // nonvolatile store
   input  wire        i_nv_busy,
   input  wire        i_nv_load,
   input  wire [15:0] i_nv_upper,
   input  wire [15:0] i_nv_lower,
   input  wire [4:0]  i_nv_cfg,
   // pins
   input  wire [2:0]  i_addr_strap,
   input  wire        i_conversion_trigger_input,
   output reg         o_open_drain_out_o,
   output reg         o_open_drain_out_oe_n
);

   // shadow copies
   reg [15:0] upper_reg;
   reg [15:0] lower_reg;
   reg [15:0] temp_reg;
   reg [7:0]  user_reg [0:3];
   reg [1:0]  res_reg;
   reg        autostart_reg;
   reg        single_reg;
   reg        out2_reg;
   reg        out1_reg;
   reg        highf_reg;
   reg        lowf_reg;
   reg        nvb_reg;
   // thermostat and conversion state
   reg        alarm_reg;
   reg        alarm_next;
   reg        state_reg;
   reg        powerup_reg;
   reg        trig_prev_reg;
   // next values of the clocked state
   reg        state_next;
   reg        start_next;
   reg        highf_next;
   reg        lowf_next;
   reg        oe_n_next;
   reg [7:0]  rdata_next;
   reg [15:0] temp_next;

   // conversion states
   localparam [0:0] ST_IDLE = 1'b0;
   localparam [0:0] ST_CONV = 1'b1;

   wire       wr_temp_lo  = i_reg_wr && (i_reg_addr == `TCC_ADDR_TEMP_LO);
   wire       wr_cfg_hi   = i_reg_wr && (i_reg_addr == `TCC_ADDR_CFG_HI);
   wire       wr_cfg_lo   = i_reg_wr && (i_reg_addr == `TCC_ADDR_CFG_LO);
   wire       converting  = (state_reg == ST_CONV);
   wire       conv_done   = converting && i_conv_valid;
   // a host write takes part in the compare only while no conversion runs
   wire       host_eval   = wr_temp_lo && !converting; // [RL2] [RL3]
   wire       eval        = conv_done || host_eval; // [RL5]
   wire [15:0] eval_temp  = conv_done ? {i_conv_data[15:3], 3'h0}
                                      : {temp_reg[15:8], i_reg_wdata & `TCC_LOW_MASK};
   // full signed compare, no masking by resolution
   wire       at_or_above = $signed(eval_temp) >= $signed(upper_reg); // [RL9]
   wire       at_or_below = $signed(eval_temp) <= $signed(lower_reg); // [RL9]
   wire       trig_rise   = autostart_reg && i_conversion_trigger_input
                            && !trig_prev_reg; // [RL13] [RL15]
   wire       start_req   = i_start_convert || trig_rise
                            || (powerup_reg && autostart_reg); // [RL13]
   wire [15:0] cfg_word   = {!converting, nvb_reg, highf_reg, lowf_reg,
                             res_reg, autostart_reg, single_reg,
                             out2_reg, out1_reg, i_addr_strap,
                             `TCC_FACTORY_BITS}; // [RL20] [RL22] [RL23]

   // thermostat hysteresis, evaluated only on a completed value
   always @*
   begin
      alarm_next = alarm_reg;
      if (eval)
      begin
         if (out1_reg)
         begin
            if (at_or_above)
               alarm_next = 1'b1; // [RL6]
            else if (at_or_below)
               alarm_next = 1'b0; // [RL6]
         end
         else
         begin
            if (at_or_below)
               alarm_next = 1'b1; // [RL7]
            else if (at_or_above)
               alarm_next = 1'b0; // [RL7]
         end
      end
   end

   // upper and lower limit bytes
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         upper_reg <= `TCC_RST_UPPER;
         lower_reg <= `TCC_RST_LOWER;
      end
      else
      begin
         if (i_nv_load)
         begin
            upper_reg <= {i_nv_upper[15:3], 3'h0};
            lower_reg <= {i_nv_lower[15:3], 3'h0};
         end
         else if (i_reg_wr)
         begin
            case (i_reg_addr)
               `TCC_ADDR_UPPER_HI: upper_reg[15:8] <= i_reg_wdata; // [RL8]
               `TCC_ADDR_UPPER_LO: upper_reg[7:0]  <= i_reg_wdata & `TCC_LOW_MASK; // [RL8]
               `TCC_ADDR_LOWER_HI: lower_reg[15:8] <= i_reg_wdata; // [RL8]
               `TCC_ADDR_LOWER_LO: lower_reg[7:0]  <= i_reg_wdata & `TCC_LOW_MASK; // [RL8]
               default:            upper_reg       <= upper_reg;
            endcase
         end
      end
   end

   // temperature shadow; a result landing with a host write wins, the
   // written value is stale by then
   always @*
   begin
      temp_next = temp_reg;
      if (conv_done)
         temp_next = {i_conv_data[15:3], 3'h0}; // [RL1]
      else if (i_reg_wr && (i_reg_addr == `TCC_ADDR_TEMP_HI))
         temp_next[15:8] = i_reg_wdata;
      else if (wr_temp_lo)
         temp_next[7:0] = i_reg_wdata & `TCC_LOW_MASK;
   end

   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         temp_reg <= `TCC_RST_TEMP;
      else
         temp_reg <= temp_next;
   end

   // sticky flags; a set wins over a same-cycle clear so no crossing is
   // lost to a badly timed host clear
   always @*
   begin
      highf_next = highf_reg;
      lowf_next  = lowf_reg;
      if (eval && at_or_above)
         highf_next = 1'b1; // [RL11]
      else if (wr_cfg_hi && !i_reg_wdata[`TCC_CFG_HIGHF-8])
         highf_next = 1'b0; // [RL12]
      if (eval && at_or_below)
         lowf_next = 1'b1; // [RL11]
      else if (wr_cfg_hi && !i_reg_wdata[`TCC_CFG_LOWF-8])
         lowf_next = 1'b0; // [RL12]
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_user
         always @(posedge i_clk or posedge i_reset)
         begin
            if (i_reset)
               user_reg[gi] <= `TCC_RST_USER;
            else if (i_reg_wr && (i_reg_addr == `TCC_ADDR_USER_0 + gi[7:0]))
               user_reg[gi] <= i_reg_wdata; // [RL18] [RL19]
         end
      end
   endgenerate

   // configuration bits and sticky flags
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         res_reg       <= `TCC_RST_RES;
         autostart_reg <= `TCC_RST_AUTOSTART;
         single_reg    <= `TCC_RST_SINGLE;
         out2_reg      <= `TCC_RST_OUT2;
         out1_reg      <= `TCC_RST_OUT1;
         highf_reg     <= 1'b0;
         lowf_reg      <= 1'b0;
         nvb_reg       <= 1'b0;
      end
      else
      begin
         nvb_reg <= i_nv_busy; // [RL23]
         if (i_nv_load)
         begin
            res_reg       <= i_nv_cfg[4:3]; // [RL21]
            autostart_reg <= i_nv_cfg[2]; // [RL21]
            single_reg    <= i_nv_cfg[1]; // [RL21]
            out1_reg      <= i_nv_cfg[0]; // [RL21]
         end
         else if (wr_cfg_hi)
         begin
            res_reg       <= i_reg_wdata[`TCC_CFG_RES_HI-8:`TCC_CFG_RES_LO-8];
            autostart_reg <= i_reg_wdata[`TCC_CFG_AUTOSTART-8];
            single_reg    <= i_reg_wdata[`TCC_CFG_SINGLE-8];
         end
         else if (wr_cfg_lo)
         begin
            out2_reg <= i_reg_wdata[`TCC_CFG_OUT2]; // [RL16] [RL17]
            out1_reg <= i_reg_wdata[`TCC_CFG_OUT1]; // [RL16] [RL17]
         end
         highf_reg <= highf_next; // [RL11] [RL12]
         lowf_reg  <= lowf_next; // [RL11] [RL12]
      end
   end

   // conversion sequencing; a stop in the same cycle as a start wins
   always @*
   begin
      state_next = state_reg;
      start_next = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            if (start_req && !i_stop_convert)
            begin
               state_next = ST_CONV; // [RL13] [RL15]
               start_next = 1'b1;
            end
         end
         ST_CONV:
         begin
            if (i_stop_convert)
               state_next = ST_IDLE;
            else if (conv_done)
            begin
               // continuous mode restarts at once, single mode rests
               if (single_reg)
                  state_next = ST_IDLE; // [RL14]
               else
                  start_next = 1'b1; // [RL14]
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_reg     <= ST_IDLE;
         powerup_reg   <= 1'b1;
         trig_prev_reg <= 1'b1;
         o_conv_start  <= 1'b0;
      end
      else
      begin
         powerup_reg   <= 1'b0;
         trig_prev_reg <= i_conversion_trigger_input;
         state_reg     <= state_next;
         o_conv_start  <= start_next;
      end
   end

   // pin follows a rewrite of the out2 bit on the second edge after the write
   always @*
   begin
      if (!out2_reg)
         oe_n_next = 1'b0; // [RL16] [RL17]
      else
         oe_n_next = !alarm_next; // [RL6] [RL7]
   end

   // thermostat state and pin
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         alarm_reg             <= 1'b0;
         o_open_drain_out_o    <= 1'b0;
         o_open_drain_out_oe_n <= 1'b1;
         o_resolution          <= `TCC_RST_RES;
      end
      else
      begin
         alarm_reg          <= alarm_next; // [RL5]
         o_open_drain_out_o <= 1'b0;
         o_resolution       <= res_reg;
         o_open_drain_out_oe_n <= oe_n_next; // [RL5]
      end
   end

   // read byte select; undefined and unmapped bytes read zero
   always @*
   begin
      case (i_reg_addr) // [RL18] [RL19]
         `TCC_ADDR_UPPER_HI: rdata_next = upper_reg[15:8];
         `TCC_ADDR_UPPER_LO: rdata_next = upper_reg[7:0];
         `TCC_ADDR_LOWER_HI: rdata_next = lower_reg[15:8];
         `TCC_ADDR_LOWER_LO: rdata_next = lower_reg[7:0];
         `TCC_ADDR_USER_0:   rdata_next = user_reg[0];
         `TCC_ADDR_USER_1:   rdata_next = user_reg[1];
         `TCC_ADDR_USER_2:   rdata_next = user_reg[2];
         `TCC_ADDR_USER_3:   rdata_next = user_reg[3];
         `TCC_ADDR_TEMP_HI:  rdata_next = temp_reg[15:8];
         `TCC_ADDR_TEMP_LO:  rdata_next = temp_reg[7:0];
         `TCC_ADDR_CFG_HI:   rdata_next = cfg_word[15:8];
         `TCC_ADDR_CFG_LO:   rdata_next = cfg_word[7:0];
         default:            rdata_next = 8'h00;
      endcase
   end

   // register reads and nonvolatile write notice
   always @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_reg_rdata    <= 8'h00;
         o_reg_nv_write <= 1'b0;
      end
      else
      begin
         o_reg_nv_write <= i_reg_wr && (((i_reg_addr >= `TCC_ADDR_UPPER_HI)
                           && (i_reg_addr <= `TCC_ADDR_USER_3))
                           || (i_reg_addr == `TCC_ADDR_CFG_HI)
                           || (i_reg_addr == `TCC_ADDR_CFG_LO)); // [RL21]
         // data stands until the next read
         if (i_reg_rd)
            o_reg_rdata <= rdata_next; // [RL19]
      end
   end

endmodule

// *** testbench/tcc_conv_model.sv ***
/*
 converter stand-in: one result pulse per start pulse, after DLY cycles.
 assumes one-cycle start pulses on the rising edge.
*/
module tcc_conv_model
#(
   parameter DLY = 20
)
(
   input  wire logic        i_clk,
   input  wire logic        i_start,
   input  wire logic [15:0] i_temp,
   output logic             o_valid,
   output logic [15:0]      o_data
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial o_valid = 1'b0;
   initial o_data = 16'hFFFF;
   // data toggles outside valid so a stale value is never mistaken for a result
   always @(posedge i_clk)
   begin
      if (i_start)
         cnt <= DLY;
      else if (cnt != 0)
         cnt <= cnt - 1;
      if (!i_start && cnt == 1)
      begin
         o_valid <= 1'b1;
         o_data <= i_temp;
      end
      else
      begin
         o_valid <= 1'b0;
         o_data <= ~o_data;
      end
   end
endmodule

// *** testbench/tcc_thermostat_assertions.sv ***
/*
 port checker for the thermostat block.
 assumes one clock and an async active-high reset; bound below.
*/
module tcc_thermostat_assertions
(
   input wire logic       i_clk,
   input wire logic       i_reset,
   input wire logic [7:0] i_reg_addr,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_reg_nv_write,
   input wire logic       i_conv_valid,
   input wire logic       i_nv_load,
   input wire logic       o_conv_start,
   input wire logic [1:0] o_resolution,
   input wire logic [2:0] i_addr_strap,
   input wire logic       o_open_drain_out_o,
   input wire logic       o_open_drain_out_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   wire nv_spot = (i_reg_addr >= 8'hA0 && i_reg_addr <= 8'hA7) || i_reg_addr == 8'hAC
      || i_reg_addr == 8'hAD;
   wire odd_spot = i_reg_addr < 8'hA0 || i_reg_addr > 8'hAD;
   a_od_low: assert property (o_open_drain_out_o == 1'b0)
      else $error("pin data not low");
   a_force_low: assert property (i_reg_wr && i_reg_addr == 8'hAD && !i_reg_wdata[7]
      |-> ##2 !o_open_drain_out_oe_n) else $error("forced low not applied");
   a_start_one: assert property (o_conv_start |=> !o_conv_start)
      else $error("start pulse too long");
   a_nv_pulse: assert property (i_reg_wr && nv_spot |=> o_reg_nv_write)
      else $error("missing store pulse");
   a_nv_cause: assert property (o_reg_nv_write |-> $past(i_reg_wr))
      else $error("store pulse without write");
   a_unmapped_zero: assert property (i_reg_rd && odd_spot |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_strap_read: assert property (i_reg_rd && i_reg_addr == 8'hAD
      |=> o_reg_rdata[5:0] == {$past(i_addr_strap), 3'h0}) else $error("low config byte");
   a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data moved");
   a_res_copy: assert property (i_reg_wr && i_reg_addr == 8'hAC ##2 1'b1
      |-> o_resolution == $past(i_reg_wdata[3:2], 2)) else $error("resolution copy");
   a_pin_cause: assert property ($changed(o_open_drain_out_oe_n) |-> $past(i_reg_wr)
      || $past(i_reg_wr, 2) || $past(i_conv_valid) || $past(i_conv_valid, 2)
      || $past(i_nv_load) || $past(i_nv_load, 2) || $past(i_reset) || $past(i_reset, 2))
      else $error("pin moved without cause");
   c_result: cover property (i_conv_valid ##1 !o_open_drain_out_oe_n);
   c_temp_low: cover property (i_reg_wr && i_reg_addr == 8'hAB);
   c_start: cover property (o_conv_start);
endmodule

bind tcc_thermostat tcc_thermostat_assertions i_chk (.i_clk(i_clk), .i_reset(i_reset),
   .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_nv_write(o_reg_nv_write),
   .i_conv_valid(i_conv_valid), .i_nv_load(i_nv_load), .o_conv_start(o_conv_start),
   .o_resolution(o_resolution), .i_addr_strap(i_addr_strap),
   .o_open_drain_out_o(o_open_drain_out_o), .o_open_drain_out_oe_n(o_open_drain_out_oe_n));

// *** testbench/tcc_thermostat_tb.sv ***
/*
 bench for the thermostat block: map, both hysteresis modes, flags,
 conversions, trigger pin, forced low. assumes the converter model.
*/
module tcc_thermostat_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk = 0, i_reset = 1, wr = 0, rd = 0, go = 0, stop = 0, trig = 1;
   logic        eeprom_write_busy = 0;
   logic [7:0]  addr = 8'hA0, wd = 8'h00, rdat;
   logic [15:0] m_temp = 16'h0800, cdat;
   logic [2:0]  strap = 3'h5;
   logic        cs, cv, nvw, od, oe_n;
   logic [1:0]  res;
   int          bad_count = 0, samples_checked = 0, starts = 0;
   tcc_thermostat i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat),
      .o_reg_nv_write(nvw), .i_start_convert(go), .i_stop_convert(stop),
      .o_conv_start(cs), .i_conv_valid(cv), .i_conv_data(cdat), .o_resolution(res),
      .i_nv_busy(eeprom_write_busy), .i_nv_load(1'b0), .i_nv_upper(16'h0000), .i_nv_lower(16'h0000),
      .i_nv_cfg(5'h00), .i_addr_strap(strap), .i_conversion_trigger_input(trig),
      .o_open_drain_out_o(od), .o_open_drain_out_oe_n(oe_n));
   tcc_conv_model #(.DLY(20)) i_conv (.i_clk(i_clk), .i_start(cs), .i_temp(m_temp),
      .o_valid(cv), .o_data(cdat));
   initial forever #5 i_clk = ~i_clk;
   always @(posedge i_clk)
      if (cs)
         starts <= starts + 1;
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 chk("rdata", {8'h00, rdat}, {8'h00, e});
   endtask
   // both bytes, high first, without stopping conversions
   task automatic tset(input logic [15:0] v);
      wreg(8'hAA, v[15:8]);
      wreg(8'hAB, v[7:0]);
   endtask
   task automatic pin(input logic e);
      #1 chk("oe_n", {15'h0, oe_n}, {15'h0, e});
      chk("od", {15'h0, od}, 16'h0000);
   endtask
   task automatic t_map();
      rchk(8'hA0, 8'h07);
      chk("res", {14'h0, res}, 16'h0003);
      rchk(8'hA3, 8'h00);
      rchk(8'hA2, 8'h05);
      rchk(8'hAA, 8'hE2);
      rchk(8'hAC, 8'h8C);
      rchk(8'hAD, 8'h68);
      rchk(8'hB0, 8'h00);
      wreg(8'hA5, 8'h5A);
      #1 chk("nvw", {15'h0, nvw}, 16'h0001);
      rchk(8'hA5, 8'h5A);
      wreg(8'hA1, 8'hFF);
      rchk(8'hA1, 8'hF8);
      wreg(8'hA1, 8'h80);
   endtask
   task automatic t_high();
      tset(16'h0500);
      wreg(8'hAD, 8'hC0);
      @(posedge i_clk);
      pin(1'b1);
      wreg(8'hAA, 8'h08);
      pin(1'b1);
      wreg(8'hAB, 8'h00);
      pin(1'b0);
      tset(16'h0600);
      pin(1'b0);
      tset(16'h0500);
      pin(1'b1);
      rchk(8'hAC, 8'hBC);
      wreg(8'hAC, 8'h0C);
      rchk(8'hAC, 8'h8C);
   endtask
   task automatic t_low();
      wreg(8'hAD, 8'h80);
      tset(16'h0600);
      pin(1'b1);
      tset(16'hFAF0);
      pin(1'b0);
      tset(16'h0600);
      pin(1'b0);
      tset(16'h0780);
      pin(1'b1);
      rchk(8'hAC, 8'hBC);
      wreg(8'hAC, 8'h0C);
   endtask
   task automatic t_conv();
      wreg(8'hAD, 8'hC0);
      go <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      rchk(8'hAC, 8'h0C);
      tset(16'h0000);
      for (int i = 0; i < 40 && cv !== 1'b1; i++)
         @(posedge i_clk) #1;
      @(posedge i_clk);
      pin(1'b0);
      rchk(8'hAA, 8'h08);
      rchk(8'hAC, 8'h2C);
      @(posedge i_clk);
      stop <= 1'b1;
      @(posedge i_clk);
      stop <= 1'b0;
      repeat (30) @(posedge i_clk);
      rchk(8'hAC, 8'hAC);
   endtask
   task automatic t_trig();
      int n;
      m_temp <= 16'h0500;
      wreg(8'hAC, 8'h0F);
      trig <= 1'b0;
      @(posedge i_clk);
      trig <= 1'b1;
      n = starts;
      repeat (60) @(posedge i_clk);
      #1 chk("starts", 16'(starts - n), 16'h0001);
      pin(1'b1);
      rchk(8'hAC, 8'h9F);
   endtask
   task automatic t_nv();
      @(posedge i_clk);
      eeprom_write_busy <= 1'b1;
      rchk(8'hAC, 8'hDF);
      @(posedge i_clk);
      eeprom_write_busy <= 1'b0;
      rchk(8'hAC, 8'h9F);
   endtask
   task automatic t_force();
      wreg(8'hAD, 8'h40);
      @(posedge i_clk);
      pin(1'b0);
   endtask
   task automatic print_verdict();
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b0;
      t_map();
      t_high();
      t_low();
      t_conv();
      t_trig();
      t_force();
      t_nv();
      print_verdict();
   end
   // about 200 cycles expected, so 20000 cycles means a hang
   initial
   begin
      #200000;
      bad_count++;
      print_verdict();
   end
endmodule
